// ### core/sdpi_top.sv
// Device-side pin command interface of a four-bank synchronous DRAM
`timescale 1ns/1ps
`default_nettype none
`include "sdpi_regs.svh"
// How it works
// - An edge counts only when the clock-gate input is high; otherwise ignored.
// - Clock-gate low puts device in power-down, clock suspend or self refresh.
// - Clock-gate is sampled on every edge, never gated by its own validity.
// - All other inputs are captured on rising clock edges.
// - Commands are accepted only while chip select is low.
// - Chip select high blocks new commands; a burst already running carries on.
// - Command decoded from row strobe, column strobe and write strobe together.
// - Sixteen data lines split into two independently masked byte lanes.
// - Read lane driven when its mask is low, released when high.
// - Write lane stored when its mask is low, discarded when high.
// - One shared set of two-way data lines carries all transfers.
// - Read mask registered on an edge governs data three clocks later.
// - Write mask applies on the same edge as its write data.
module sdpi_top #(
    parameter int ROW_W  = 12,
    parameter int COL_W  = 8,
    parameter int BANK_W = 2,
    parameter int DQ_W   = 16
) (
    input  wire logic              REF_CLK,
    input  wire logic              NRST,
    input  wire logic              CKE,
    input  wire logic              CS_N,
    input  wire logic              RAS_N,
    input  wire logic              CAS_N,
    input  wire logic              WE_N,
    input  wire logic [ROW_W-1:0]  ADDR,
    input  wire logic [BANK_W-1:0] BA,
    input  wire logic              LOW_BYTE_MASK,
    input  wire logic              HIGH_BYTE_MASK,
    input  wire logic [DQ_W-1:0]   DATA_IO_IN,
    output logic      [DQ_W-1:0]   DATA_IO_OUT,
    output logic      [1:0]        DATA_IO_OE_N,
    output logic      [1:0]        LP_STATE
);
    localparam int BANKS = 1 << BANK_W;
    localparam int AW    = BANK_W + ROW_W + COL_W;
    localparam int SW    = 7 + ROW_W + BANK_W + DQ_W;

    // Two-stage synchroniser on every pin, clock-gate included
    logic [SW-1:0] sync_meta;
    logic [SW-1:0] sync_pin;

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            sync_meta <= '0;
            sync_pin  <= '0;
        end else begin
            sync_meta <= {CKE, CS_N, RAS_N, CAS_N, WE_N, HIGH_BYTE_MASK,
                          LOW_BYTE_MASK, BA, ADDR, DATA_IO_IN};
            sync_pin  <= sync_meta;
        end
    end

    logic                 cke_s;
    logic                 cs_n_s;
    sdpi_pkg::sdpi_cmd_t  cmd_s;
    logic [1:0]           mask_s;
    logic [BANK_W-1:0]    ba_s;
    logic [ROW_W-1:0]     addr_s;
    logic [DQ_W-1:0]      din_s;

    assign {cke_s, cs_n_s, cmd_s, mask_s, ba_s, addr_s, din_s} = sync_pin;

    // Control state
    sdpi_pkg::sdpi_lp_e  lp;
    logic [BANKS-1:0]    bank_open;
    logic [ROW_W-1:0]    open_row [BANKS];
    logic [2:0]          bl_code;
    logic [COL_W:0]      burst_left;
    logic [COL_W-1:0]    burst_col;
    logic [BANK_W-1:0]   burst_bank;
    logic                burst_wr;
    logic                burst_ap;
    logic                rd_v1;
    logic [1:0]          mask_p1;
    logic [1:0]          oe_n;
    logic [DQ_W-1:0]     dout;

    sdpi_pkg::sdpi_lp_e  next_lp;
    logic [BANKS-1:0]    next_bank_open;
    logic [ROW_W-1:0]    next_open_row [BANKS];
    logic [2:0]          next_bl_code;
    logic [COL_W:0]      next_burst_left;
    logic [COL_W-1:0]    next_burst_col;
    logic [BANK_W-1:0]   next_burst_bank;
    logic                next_burst_wr;
    logic                next_burst_ap;
    logic                next_rd_v1;
    logic [1:0]          next_mask_p1;
    logic [1:0]          next_oe_n;
    logic [DQ_W-1:0]     next_dout;

    logic                mem_re;
    logic [1:0]          mem_we;
    logic [AW-1:0]       mem_addr;
    logic [DQ_W-1:0]     mem_rdata;

    logic                edge_ok;
    logic                cmd_go;
    logic                stop;
    logic [COL_W:0]      blen;

    always_comb begin
        case (bl_code)
            `SDPI_BL_1:    blen = (COL_W+1)'(1);
            `SDPI_BL_2:    blen = (COL_W+1)'(2);
            `SDPI_BL_4:    blen = (COL_W+1)'(4);
            `SDPI_BL_8:    blen = (COL_W+1)'(8);
            `SDPI_BL_PAGE: blen = (COL_W+1)'(1 << COL_W);
            default:       blen = (COL_W+1)'(1);
        endcase
    end

    always_comb begin
        edge_ok = cke_s;
        cmd_go  = edge_ok && !cs_n_s;
        stop    = cmd_go && (cmd_s == `SDPI_CMD_BST ||
                             cmd_s == `SDPI_CMD_PRECHG);

        next_lp         = lp;
        next_bank_open  = bank_open;
        next_open_row   = open_row;
        next_bl_code    = bl_code;
        next_burst_left = burst_left;
        next_burst_col  = burst_col;
        next_burst_bank = burst_bank;
        next_burst_wr   = burst_wr;
        next_burst_ap   = burst_ap;
        next_rd_v1      = rd_v1;
        next_mask_p1    = mask_p1;
        next_oe_n       = oe_n;
        next_dout       = dout;
        mem_re          = 1'b0;
        mem_we          = 2'b00;
        mem_addr        = {burst_bank, open_row[burst_bank], burst_col};

        // Gate state is judged on every edge, valid or not
        if (!cke_s) begin
            if (lp == sdpi_pkg::LP_RUN) begin
                if (!cs_n_s && cmd_s == `SDPI_CMD_REFRESH) begin
                    next_lp = sdpi_pkg::LP_SELFREF;
                end else if (burst_left != '0 || rd_v1) begin
                    next_lp = sdpi_pkg::LP_SUSPEND;
                end else begin
                    next_lp = sdpi_pkg::LP_PDOWN;
                end
            end
        end else begin
            next_lp = sdpi_pkg::LP_RUN;
        end

        // Invalid edges leave every pipeline frozen
        if (edge_ok) begin
            next_rd_v1   = 1'b0;
            next_mask_p1 = mask_s;
            next_dout    = mem_rdata;
            next_oe_n    = ~({2{rd_v1}} & ~mask_p1);

            if (burst_left != '0 && !stop) begin
                if (burst_wr) begin
                    mem_we = ~mask_s;
                end else begin
                    mem_re     = 1'b1;
                    next_rd_v1 = 1'b1;
                end
                next_burst_col  = burst_col + 1'b1;
                next_burst_left = burst_left - 1'b1;
                if (burst_left == (COL_W+1)'(1) && burst_ap) begin
                    next_bank_open[burst_bank] = 1'b0;
                end
            end

            // Chip select high falls through with no change
            if (cmd_go) begin
                case (cmd_s)
                    `SDPI_CMD_ACTIVE: begin
                        next_bank_open[ba_s] = 1'b1;
                        next_open_row[ba_s]  = addr_s;
                    end
                    `SDPI_CMD_READ,
                    `SDPI_CMD_WRITE: begin
                        if (bank_open[ba_s]) begin
                            mem_addr = {ba_s, open_row[ba_s],
                                        addr_s[COL_W-1:0]};
                            next_burst_bank = ba_s;
                            next_burst_col  = addr_s[COL_W-1:0] + 1'b1;
                            next_burst_left = blen - 1'b1;
                            next_burst_ap   = addr_s[`SDPI_AP_BIT];
                            next_burst_wr   = (cmd_s == `SDPI_CMD_WRITE);
                            if (cmd_s == `SDPI_CMD_WRITE) begin
                                mem_we     = ~mask_s;
                                mem_re     = 1'b0;
                                next_rd_v1 = 1'b0;
                            end else begin
                                mem_we     = 2'b00;
                                mem_re     = 1'b1;
                                next_rd_v1 = 1'b1;
                            end
                            if (blen == (COL_W+1)'(1) &&
                                addr_s[`SDPI_AP_BIT]) begin
                                next_bank_open[ba_s] = 1'b0;
                            end
                        end
                    end
                    `SDPI_CMD_PRECHG: begin
                        next_burst_left = '0;
                        if (addr_s[`SDPI_AP_BIT]) begin
                            next_bank_open = '0;
                        end else begin
                            next_bank_open[ba_s] = 1'b0;
                        end
                    end
                    `SDPI_CMD_BST: begin
                        next_burst_left = '0;
                    end
                    `SDPI_CMD_LMR: begin
                        next_bl_code = addr_s[`SDPI_BL_MSB:`SDPI_BL_LSB];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            lp         <= sdpi_pkg::LP_RUN;
            bank_open  <= '0;
            for (int b = 0; b < BANKS; b++) begin
                open_row[b] <= '0;
            end
            bl_code    <= `SDPI_BL_RST;
            burst_left <= '0;
            burst_col  <= '0;
            burst_bank <= '0;
            burst_wr   <= 1'b0;
            burst_ap   <= 1'b0;
            rd_v1      <= 1'b0;
            mask_p1    <= `SDPI_MASK_RST;
            oe_n       <= `SDPI_OE_N_RST;
            dout       <= '0;
        end else begin
            lp         <= next_lp;
            bank_open  <= next_bank_open;
            open_row   <= next_open_row;
            bl_code    <= next_bl_code;
            burst_left <= next_burst_left;
            burst_col  <= next_burst_col;
            burst_bank <= next_burst_bank;
            burst_wr   <= next_burst_wr;
            burst_ap   <= next_burst_ap;
            rd_v1      <= next_rd_v1;
            mask_p1    <= next_mask_p1;
            oe_n       <= next_oe_n;
            dout       <= next_dout;
        end
    end

    sdpi_mem #(
        .AW    (AW),
        .LW    (DQ_W/2)
    ) u_mem (
        .clk   (REF_CLK),
        .rst_n (NRST),
        .re    (mem_re),
        .we    (mem_we),
        .addr  (mem_addr),
        .wdata (din_s),
        .rdata (mem_rdata)
    );

    // Enables per lane, low while driving the shared lines
    assign DATA_IO_OUT  = dout;
    assign DATA_IO_OE_N = oe_n;
    assign LP_STATE     = lp;
endmodule
`default_nettype wire

// ### core/sdpi_regs.svh
// Command codes, field positions and reset values of the pin interface
`ifndef SDPI_REGS_SVH
`define SDPI_REGS_SVH

// Command code is {row strobe, column strobe, write strobe}, all active low
`define SDPI_CMD_LMR      3'h0
`define SDPI_CMD_REFRESH  3'h1
`define SDPI_CMD_PRECHG   3'h2
`define SDPI_CMD_ACTIVE   3'h3
`define SDPI_CMD_WRITE    3'h4
`define SDPI_CMD_READ     3'h5
`define SDPI_CMD_BST      3'h6
`define SDPI_CMD_NOP      3'h7

// Address field positions
`define SDPI_AP_BIT       10
`define SDPI_BL_LSB       0
`define SDPI_BL_MSB       2

// Burst length codes
`define SDPI_BL_1         3'h0
`define SDPI_BL_2         3'h1
`define SDPI_BL_4         3'h2
`define SDPI_BL_8         3'h3
`define SDPI_BL_PAGE      3'h7

// Reset values
`define SDPI_BL_RST       3'h0
`define SDPI_MASK_RST     2'h3
`define SDPI_OE_N_RST     2'h3

`endif

// ### core/sdpi_pkg.sv
// Types shared by the pin interface files
`default_nettype none
package sdpi_pkg;
    typedef enum logic [1:0] {
        LP_RUN,
        LP_PDOWN,
        LP_SUSPEND,
        LP_SELFREF
    } sdpi_lp_e;

    typedef logic [2:0] sdpi_cmd_t;
endpackage
`default_nettype wire

// ### core/sdpi_mem.sv
// Storage array with per-byte write enables and registered read data
`timescale 1ns/1ps
`default_nettype none
module sdpi_mem #(
    parameter int AW = 22,
    parameter int LW = 8
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              re,
    input  wire logic [1:0]        we,
    input  wire logic [AW-1:0]     addr,
    input  wire logic [2*LW-1:0]   wdata,
    output logic      [2*LW-1:0]   rdata
);
    logic [2*LW-1:0] mem [0:(1<<AW)-1];
    logic [2*LW-1:0] next_rdata;

    always_comb begin
        next_rdata = rdata;
        if (re) begin
            next_rdata = mem[addr];
        end
    end

    // Array has no reset; only the read register does
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (we[i]) begin
                mem[addr][i*LW +: LW] <= wdata[i*LW +: LW];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ### dv/sdpi_top_assertions.sv
// Concurrent checks on the pin interface ports of the device
`timescale 1ns/1ps
`default_nettype none
`include "sdpi_regs.svh"
module sdpi_top_chk #(
    parameter int ROW_W  = 12,
    parameter int COL_W  = 8,
    parameter int BANK_W = 2,
    parameter int DQ_W   = 16
) (
    input wire logic              REF_CLK,
    input wire logic              NRST,
    input wire logic              CKE,
    input wire logic              CS_N,
    input wire logic              RAS_N,
    input wire logic              CAS_N,
    input wire logic              WE_N,
    input wire logic [ROW_W-1:0]  ADDR,
    input wire logic [BANK_W-1:0] BA,
    input wire logic              LOW_BYTE_MASK,
    input wire logic              HIGH_BYTE_MASK,
    input wire logic [DQ_W-1:0]   DATA_IO_IN,
    input wire logic [DQ_W-1:0]   DATA_IO_OUT,
    input wire logic [1:0]        DATA_IO_OE_N,
    input wire logic [1:0]        LP_STATE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    logic [6:0] lo;
    logic [6:0] hi;
    logic [6:0] rd;
    logic [6:0] next_lo;
    logic [6:0] next_hi;
    logic [6:0] next_rd;
    logic       rd_now;
    assign rd_now = CKE && !CS_N && {RAS_N, CAS_N, WE_N} == `SDPI_CMD_READ;
    // Pin history lets the lane checks span the synchroniser delay
    always_comb begin
        next_lo = {lo[5:0], LOW_BYTE_MASK};
        next_hi = {hi[5:0], HIGH_BYTE_MASK};
        next_rd = {rd[5:0], rd_now};
    end
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            lo <= '0;
            hi <= '0;
            rd <= '0;
        end else begin
            lo <= next_lo;
            hi <= next_hi;
            rd <= next_rd;
        end
    end
    lo_lane_a: assert property (!DATA_IO_OE_N[0] |-> !(&lo[5:1]))
        else $error("low lane driven while its mask was high");
    hi_lane_a: assert property (!DATA_IO_OE_N[1] |-> !(&hi[5:1]))
        else $error("high lane driven while its mask was high");
    rd_cause_a: assert property (DATA_IO_OE_N != 2'b11 |-> |rd[5:1])
        else $error("data lines driven with no read taken");
    cs_idle_a: assert property (CS_N [*8] |-> DATA_IO_OE_N == 2'b11)
        else $error("lines driven while deselected");
    cke_low_a: assert property (!CKE [*5] |-> LP_STATE != 2'h0)
        else $error("no low power state with clock gate low");
    cke_run_a: assert property (CKE [*5] |-> LP_STATE == 2'h0)
        else $error("low power state with clock gate high");
    freeze_a: assert property (!CKE [*4] |=> $stable(DATA_IO_OUT)
        && $stable(DATA_IO_OE_N)) else $error("outputs moved on ignored edge");
    sref_a: assert property ((!CKE && !CS_N && {RAS_N, CAS_N, WE_N} ==
        `SDPI_CMD_REFRESH) ##1 !CKE [*5] |-> LP_STATE == 2'h3)
        else $error("refresh with clock gate low missed self refresh");
    cover property (DATA_IO_OE_N == 2'b01);
    cover property (LP_STATE == 2'h1);
    cover property (LP_STATE == 2'h3);
    cover property (!DATA_IO_OE_N[0] ##1 !DATA_IO_OE_N[0]);
endmodule
// Widths other than the row address follow the checker's defaults
bind sdpi_top sdpi_top_chk #(.ROW_W(ROW_W)) chk_u (
    .REF_CLK(REF_CLK), .NRST(NRST), .CKE(CKE),
    .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .ADDR(ADDR),
    .BA(BA), .LOW_BYTE_MASK(LOW_BYTE_MASK), .HIGH_BYTE_MASK(HIGH_BYTE_MASK),
    .DATA_IO_IN(DATA_IO_IN), .DATA_IO_OUT(DATA_IO_OUT),
    .DATA_IO_OE_N(DATA_IO_OE_N), .LP_STATE(LP_STATE));
`default_nettype wire

// ### dv/sdpi_ctrl_model.sv
// Behavioural memory controller driving the device pins
`timescale 1ns/1ps
`default_nettype none
`include "sdpi_regs.svh"
module sdpi_ctrl_model #(
    parameter int AW = 12
) (
    input  wire logic        clk,
    output logic             cke,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [AW-1:0]    addr,
    output logic [1:0]       ba,
    output logic             lo_mask,
    output logic             hi_mask,
    output logic [15:0]      dq_in,
    input  wire logic [15:0] dq_out,
    input  wire logic [1:0]  dq_oe_n
);
    logic        dq_en = 1'b0;
    logic [15:0] wd = 16'h0000;
    logic        flip = 1'b0;
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n, lo_mask, hi_mask} = 7'h7f;
        addr = '0;
        ba = 2'h0;
    end
    always @(posedge clk) flip <= ~flip;
    // Released lanes toggle so a stale value never passes for data
    assign dq_in[7:0]  = !dq_oe_n[0] ? dq_out[7:0]
                       : dq_en ? wd[7:0] : {8{flip}};
    assign dq_in[15:8] = !dq_oe_n[1] ? dq_out[15:8]
                       : dq_en ? wd[15:8] : {8{flip}};
    task automatic op(input logic k, input logic s, input logic [2:0] c,
            input logic [1:0] b, input logic [AW-1:0] a, input logic [1:0] m,
            input logic [15:0] d);
        @(posedge clk);
        cke <= k;
        cs_n <= s;
        {ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        {hi_mask, lo_mask} <= m;
        wd <= d;
        dq_en <= c == `SDPI_CMD_WRITE;
    endtask
    task automatic idle(input int n);
        repeat (n) op(1'b1, 1'b1, `SDPI_CMD_NOP, 2'h0, '0, 2'h3,
                      16'h0000);
    endtask
endmodule
`default_nettype wire

// ### dv/tb_sdram_pin_command_interface.sv
// Self-checking bench for the pin command interface
`timescale 1ns/1ps
`default_nettype none
`include "sdpi_regs.svh"
module tb_sdram_pin_command_interface;
    typedef struct packed {
        logic [1:0]  oe_n;
        logic [15:0] d;
    } sdpi_exp_s;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        lo_m;
    logic        hi_m;
    logic [10:0] addr;
    logic [1:0]  ba;
    logic [1:0]  oe_n;
    logic [1:0]  lp;
    logic [15:0] din;
    logic [15:0] dout;
    logic [15:0] sh [64];
    logic [15:0] lf = 16'hb064;
    sdpi_exp_s   q [$];
    sdpi_exp_s   e;
    int          err_total = 0;
    int          cmp_count = 0;
    always #10 ref_clk = ~ref_clk;
    sdpi_top #(.ROW_W(11), .COL_W(4)) dut_u (
        .REF_CLK(ref_clk), .NRST(nrst), .CKE(cke), .CS_N(cs_n),
        .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .ADDR(addr), .BA(ba),
        .LOW_BYTE_MASK(lo_m), .HIGH_BYTE_MASK(hi_m), .DATA_IO_IN(din),
        .DATA_IO_OUT(dout), .DATA_IO_OE_N(oe_n), .LP_STATE(lp));
    sdpi_ctrl_model #(.AW(11)) m_u (
        .clk(ref_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .addr(addr), .ba(ba), .lo_mask(lo_m), .hi_mask(hi_m),
        .dq_in(din), .dq_out(dout), .dq_oe_n(oe_n));
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [15:0] lanes(input logic [1:0] m);
        return {{8{~m[1]}}, {8{~m[0]}}};
    endfunction
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [1:0] b, input logic [3:0] c,
            input logic [1:0] m);
        lf = lfsr_next(lf);
        m_u.op(1'b1, 1'b0, `SDPI_CMD_WRITE, b, {7'h00, c}, m, lf);
        sh[{b, c}] = (sh[{b, c}] & ~lanes(m)) | (lf & lanes(m));
    endtask
    // Mask held over the following cycle too, so either mask edge governs
    task automatic rd(input logic [1:0] b, input logic [3:0] c,
            input logic [1:0] m, input logic s);
        m_u.op(1'b1, s, `SDPI_CMD_READ, b, {7'h00, c}, m, 16'h0000);
        m_u.op(1'b1, s, `SDPI_CMD_NOP, 2'h0, 11'h000, m, 16'h0000);
        if (m != 2'b11 && !s) q.push_back({m, sh[{b, c}]});
    endtask
    // Burst read from column 0; beat j takes the mask of cycle j, and a
    // burst stop on cycle cut ends the burst before that beat
    task automatic rdb(input logic [1:0] b, input int len, input int cut);
        logic [1:0]          m;
        sdpi_pkg::sdpi_cmd_t c;
        for (int j = 0; j < len; j++) begin
            lf = lfsr_next(lf);
            m = lf[1:0];
            c = j == 0 ? `SDPI_CMD_READ : j == cut ? `SDPI_CMD_BST
                                                  : `SDPI_CMD_NOP;
            m_u.op(1'b1, 1'b0, c, b, 11'h000, m, 16'h0000);
            if (j < cut && m != 2'b11) q.push_back({m, sh[{b, 4'(j)}]});
        end
    endtask
    task automatic drain(input string name);
        for (int n = 0; n < 20 && q.size() != 0; n++) m_u.idle(1);
        m_u.idle(8);
        chk(18'(q.size()), 18'h0_0000);
        if (q.size() != 0) results();
        $display("test %s done", name);
    endtask
    task automatic lp_is(input logic [1:0] want);
        @(negedge ref_clk);
        chk({16'h0000, lp}, {16'h0000, want});
    endtask
    always @(posedge ref_clk) begin
        if (nrst === 1'b1 && oe_n !== 2'b11) begin
            if (q.size() == 0) begin
                chk({oe_n, 16'h0000}, 18'h3_0000);
            end else begin
                e = q.pop_front();
                chk({oe_n, dout & lanes(oe_n)},
                    {e.oe_n, e.d & lanes(e.oe_n)});
            end
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        m_u.op(1'b1, 1'b0, `SDPI_CMD_LMR, 2'h0, {8'h00, `SDPI_BL_1}, 2'h3,
               16'h0000);
        for (int b = 0; b < 4; b++) begin
            m_u.op(1'b1, 1'b0, `SDPI_CMD_ACTIVE, 2'(b), 11'h005, 2'h3,
                   16'h0000);
        end
        for (int i = 0; i < 16; i++) begin
            wr(2'(i / 4), 4'(i % 4), 2'b00);
            wr(2'(i / 4), 4'(i % 4), 2'(i % 4));
        end
        for (int i = 0; i < 16; i++) rd(2'(i / 4), 4'(i % 4), 2'b00, 1'b0);
        drain("byte mask write");
        for (int m = 1; m < 4; m++) rd(2'h0, 4'(m), 2'(m), 1'b0);
        drain("read mask");
        m_u.op(1'b1, 1'b1, `SDPI_CMD_WRITE, 2'h2, 11'h000, 2'h0, 16'hdead);
        m_u.op(1'b1, 1'b1, `SDPI_CMD_PRECHG, 2'h2, 11'h400, 2'h3, 16'h0000);
        rd(2'h2, 4'h0, 2'b00, 1'b1);
        rd(2'h2, 4'h0, 2'b00, 1'b0);
        drain("deselect");
        m_u.op(1'b0, 1'b0, `SDPI_CMD_WRITE, 2'h3, 11'h000, 2'h0, 16'hbeef);
        repeat (6) m_u.op(1'b0, 1'b1, `SDPI_CMD_NOP, 2'h0, 11'h000, 2'h3,
                          16'h0000);
        lp_is(sdpi_pkg::LP_PDOWN);
        m_u.idle(6);
        lp_is(sdpi_pkg::LP_RUN);
        rd(2'h3, 4'h0, 2'b00, 1'b0);
        drain("clock gate");
        m_u.op(1'b0, 1'b0, `SDPI_CMD_REFRESH, 2'h0, 11'h000, 2'h3, 16'h0000);
        repeat (6) m_u.op(1'b0, 1'b1, `SDPI_CMD_NOP, 2'h0, 11'h000, 2'h3,
                          16'h0000);
        lp_is(sdpi_pkg::LP_SELFREF);
        m_u.idle(6);
        lp_is(sdpi_pkg::LP_RUN);
        $display("test self refresh done");
        // Bursts of two, then of four cut by a burst stop after two beats
        m_u.op(1'b1, 1'b0, `SDPI_CMD_LMR, 2'h0, 11'(`SDPI_BL_2), 2'h3,
               16'h0000);
        rdb(2'h1, 2, 2);
        m_u.op(1'b1, 1'b0, `SDPI_CMD_LMR, 2'h0, 11'(`SDPI_BL_4), 2'h3,
               16'h0000);
        rdb(2'h2, 4, 2);
        drain("burst");
        results();
    end
endmodule
`default_nettype wire
